/* File: pkg/iett_pkg.sv */
// Package with constants for the input event time tagger
package iett_pkg;
    // =====================================================================
    // Timing in state times (one state time is one clk cycle)
    // =====================================================================
    localparam int SAMPLE_STATES = 9;
    localparam int TIMER_STATES  = 8;
    localparam int HOLD_STATES   = 8;
    localparam int LINES         = 4;
    localparam int TAG_W         = 16;
    localparam int DEPTH         = 8;
    localparam int PTR_W         = 3;
    localparam int ENTRY_W       = LINES + TAG_W;
    localparam logic [3:0] SAMPLE_LAST = 4'(SAMPLE_STATES - 1);
    localparam logic [2:0] TIMER_LAST  = 3'(TIMER_STATES - 1);
    localparam logic [3:0] HOLD_LAST   = 4'(HOLD_STATES - 1);
endpackage : iett_pkg

/* File: src/iett_mem.sv */
// Small event memory with registered read data
`timescale 1ns/1ns
module iett_mem #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        rd_data <= mem_reg[rd_addr];
    end
endmodule : iett_mem

/* File: src/iett_top.sv */
// Fast input capture unit: sampling, time tagging, event queue, holding register
// Function
// RULE1: Sample capture lines once every 9 states
// RULE2: Faster transitions on one line may drop
// RULE3: Timer steps every 8; one value skipped
// RULE4: First two same-phase events share one tag
// RULE5: Close second event, other phase: tag plus one
// RULE6: If next is skipped value, tag plus two
// RULE7: Lone first event moves to holding after 8
// RULE8: Later event acts as fresh first event
// RULE9: Entries hold lines and tag, in order
`timescale 1ns/1ns
module iett_top
    import iett_pkg::*;
#(
    parameter int NLINES = iett_pkg::LINES,
    parameter int QDEPTH = iett_pkg::DEPTH
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [iett_pkg::LINES-1:0]  event_lines,
    input  wire logic                        hold_read,
    output logic                             hold_valid,
    output logic [iett_pkg::LINES-1:0]       hold_lines,
    output logic [iett_pkg::TAG_W-1:0]       hold_tag,
    output logic                             queue_empty,
    output logic                             queue_full,
    output logic                             overflow
);
    import iett_pkg::*;

    // =====================================================================
    // Input synchronisers
    // =====================================================================
    logic [LINES-1:0] sync1_reg;
    logic [LINES-1:0] sync2_reg;
    logic [LINES-1:0] last_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= event_lines;
            sync2_reg <= sync1_reg;
        end
    end

    // =====================================================================
    // Sample phase and time base
    // =====================================================================
    logic [3:0]       samp_cnt_reg;
    logic [2:0]       tick_cnt_reg;
    logic [TAG_W-1:0] timer_reg;
    logic             sample_now;
    logic             timer_step;

    assign sample_now = (samp_cnt_reg == SAMPLE_LAST);
    assign timer_step = (tick_cnt_reg == TIMER_LAST);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            samp_cnt_reg <= '0;
        end else if (sample_now) begin
            samp_cnt_reg <= '0; // [RULE1]
        end else begin
            samp_cnt_reg <= samp_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick_cnt_reg <= '0;
            timer_reg    <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 3'h1;
            if (timer_step) begin
                timer_reg <= timer_reg + 16'h0001; // [RULE3]
            end
        end
    end

    // Edges seen only at sample points; quicker toggles between them vanish
    logic [LINES-1:0] changed;
    logic             capture;
    assign changed = sync2_reg ^ last_reg; // [RULE2]
    assign capture = sample_now && (changed != '0); // [RULE1]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_reg <= '0;
        end else if (sample_now) begin
            last_reg <= sync2_reg;
        end
    end

    // =====================================================================
    // Tag logic for first entries and close followers
    // =====================================================================
    // Tag is the timer seen at the sample point; since 9 > 8, one timer
    // value per nine counts is never seen, which yields the skipped value.
    logic [TAG_W-1:0] tag;
    logic [TAG_W-1:0] prev_tag_reg;
    logic             prev_valid_reg;
    logic [3:0]       since_reg;

    always_comb begin
        tag = timer_reg; // [RULE3]
        if (prev_valid_reg && since_reg < SAMPLE_LAST + 4'h1) begin
            // Close follower: previous tag plus one, or two past a skip
            if (timer_reg == prev_tag_reg + 16'h0002) begin
                tag = prev_tag_reg + 16'h0002; // [RULE6]
            end else begin
                tag = prev_tag_reg + 16'h0001; // [RULE5]
            end
        end
    end

    // =====================================================================
    // Event queue
    // =====================================================================
    logic [PTR_W:0]   wr_ptr_reg;
    logic [PTR_W:0]   rd_ptr_reg;
    logic [PTR_W:0]   count;
    logic             q_empty;
    logic             q_full;
    logic             pop;
    logic             push;
    logic [3:0]       dwell_reg;
    logic [ENTRY_W-1:0] rd_word;
    logic             pend_reg;

    assign count   = wr_ptr_reg - rd_ptr_reg;
    assign q_empty = (count == '0);
    assign q_full  = (count == (PTR_W+1)'(QDEPTH));
    assign push    = capture && !q_full;
    assign queue_empty = q_empty;
    assign queue_full  = q_full;

    // Head entry must sit HOLD_STATES before leaving; read data is registered
    assign pop = !q_empty && !hold_valid && !pend_reg && dwell_reg == HOLD_LAST; // [RULE7]

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dwell_reg <= '0;
        end else if (q_empty || pop) begin
            dwell_reg <= '0;
        end else if (dwell_reg != HOLD_LAST) begin
            dwell_reg <= dwell_reg + 4'h1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1; // [RULE9]
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1; // [RULE9]
            end
        end
    end

    // Shared tag: one entry holds all lines changed at the same sample
    iett_mem #(
        .WIDTH (ENTRY_W),
        .DEPTH (QDEPTH),
        .AW    (PTR_W)
    ) u_mem (
        .clk     (clk),
        .wr_en   (push),
        .wr_addr (wr_ptr_reg[PTR_W-1:0]),
        .wr_data ({changed, tag}), // [RULE4] [RULE9]
        .rd_addr (rd_ptr_reg[PTR_W-1:0]),
        .rd_data (rd_word)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow <= 1'b0;
        end else begin
            overflow <= capture && q_full;
        end
    end

    // Tracks the previous entry only while the queue was empty at its arrival
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_valid_reg <= 1'b0;
            prev_tag_reg   <= '0;
            since_reg      <= '0;
        end else if (push && q_empty && !prev_valid_reg) begin
            prev_valid_reg <= 1'b1; // [RULE8]
            prev_tag_reg   <= tag;
            since_reg      <= '0;
        end else if (prev_valid_reg) begin
            if (pop || since_reg == SAMPLE_LAST) begin
                prev_valid_reg <= 1'b0; // [RULE8]
            end
            since_reg <= since_reg + 4'h1;
            if (push) begin
                prev_valid_reg <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Holding register
    // =====================================================================
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_reg <= 1'b0;
        end else begin
            pend_reg <= pop;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_valid <= 1'b0;
            hold_lines <= '0;
            hold_tag   <= '0;
        end else if (pend_reg) begin
            hold_valid <= 1'b1; // [RULE7]
            hold_lines <= rd_word[ENTRY_W-1:TAG_W];
            hold_tag   <= rd_word[TAG_W-1:0];
        end else if (hold_read) begin
            hold_valid <= 1'b0;
        end
    end
endmodule : iett_top

/* File: verification/iett_lines_model.sv */
// Model of the external event lines
`timescale 1ns/1ns
module iett_lines_model (
    input  wire logic                 rst,
    output logic [iett_pkg::LINES-1:0] lines
);
    // Lines rest low through reset, as the block assumes
    initial lines = '0;
    always @(posedge rst) lines = '0;
    task automatic toggle(input logic [iett_pkg::LINES-1:0] m);
        lines = lines ^ m;
    endtask : toggle
endmodule : iett_lines_model

/* File: verification/iett_top_asserts.sv */
// Concurrent checks on the ports of the input event time tagger
`timescale 1ns/1ns
module iett_top_asserts #(
    parameter int NLINES = 4,
    parameter int QDEPTH = 8
) (
    input wire logic                       clk,
    input wire logic                       rst,
    input wire logic [iett_pkg::LINES-1:0] event_lines,
    input wire logic                       hold_read,
    input wire logic                       hold_valid,
    input wire logic [iett_pkg::LINES-1:0] hold_lines,
    input wire logic [iett_pkg::TAG_W-1:0] hold_tag,
    input wire logic                       queue_empty,
    input wire logic                       queue_full,
    input wire logic                       overflow
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // =========================================================
    // Properties
    // =========================================================
    property p_space;
        $fell(queue_empty) |=> (!$fell(queue_empty)) [*8];
    endproperty
    a_space: assert property (p_space) else $error("pushes closer than 9 cycles");
    property p_move;
        $fell(queue_empty) && !hold_valid && $past(queue_empty, 3)
            |-> ##[7:9] queue_empty ##[1:3] hold_valid;
    endproperty
    a_move: assert property (p_move) else $error("lone entry not moved to holding");
    property p_stand;
        hold_valid && !hold_read |=> hold_valid && $stable(hold_tag) && $stable(hold_lines);
    endproperty
    a_stand: assert property (p_stand) else $error("holding entry changed unread");
    property p_lines;
        $rose(hold_valid) |-> hold_lines != '0;
    endproperty
    a_lines: assert property (p_lines) else $error("entry without changed lines");
    property p_read;
        hold_valid && hold_read |=> !hold_valid;
    endproperty
    a_read: assert property (p_read) else $error("holding not freed by read");
    property p_ovf_full;
        overflow |-> $past(queue_full);
    endproperty
    a_ovf_full: assert property (p_ovf_full) else $error("overflow without full queue");
    property p_ovf_pulse;
        overflow |=> !overflow;
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow longer than one cycle");
    property p_excl;
        queue_full |-> !queue_empty;
    endproperty
    a_excl: assert property (p_excl) else $error("queue both full and empty");
endmodule : iett_top_asserts

/* File: verification/iett_top_tb.sv */
// Self-checking testbench for the input event time tagger
`timescale 1ns/1ns
module iett_top_tb;
    import iett_pkg::*;
    logic             clk, rst, hold_read, hold_valid, queue_empty, queue_full, overflow;
    logic [LINES-1:0] event_lines, hold_lines, l;
    logic [TAG_W-1:0] hold_tag, t, t0;
    int               errors, checks, n2, k;
    // Toggle mask, changed lines, tag: timer seen at the sample, one step per 8 from release
    logic [15:0]      rows [6] = '{16'h1102, 16'h2204, 16'h4406, 16'h8808, 16'h550B, 16'hFF0D};
    iett_lines_model u_lines (.rst(rst), .lines(event_lines));
    iett_top u_dut (.clk(clk), .rst(rst), .event_lines(event_lines), .hold_read(hold_read),
        .hold_valid(hold_valid), .hold_lines(hold_lines), .hold_tag(hold_tag),
        .queue_empty(queue_empty), .queue_full(queue_full), .overflow(overflow));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("BAD at %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for the holding entry, then a one-cycle read pulse
    task automatic get(output logic [LINES-1:0] gl, output logic [TAG_W-1:0] gt);
        int n;
        n = 0;
        while (hold_valid !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (n >= 60) begin
            errors++;
            stop_test();
        end else begin
            gl = hold_lines;
            gt = hold_tag;
            hold_read = 1'b1;
            @(negedge clk);
            hold_read = 1'b0;
        end
    endtask : get
    initial begin
        rst = 1'b1;
        hold_read = 1'b0;
        errors = 0;
        checks = 0;
        repeat (4) @(negedge clk);
        chk({hold_valid, queue_empty, queue_full, overflow}, 4'h4);
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (12) @(negedge clk);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            u_lines.toggle(rows[i][15:12]);
            get(l, t);
            chk(l, rows[i][11:8]);
            chk(t, rows[i][7:0]);
        end
        $display("test rows done");
        // Ten events on consecutive sample points: nine fit, the tenth is dropped
        for (int i = 0; i < 10; i++) begin
            u_lines.toggle(i[0] ? 4'h2 : 4'h1);
            // Overflow pulse comes eight cycles later and lasts one cycle: watch from here
            if (i < 9) repeat (9) @(negedge clk);
        end
        k = 0;
        while (overflow !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        chk(k < 20, 1);
        chk(queue_full, 1);
        n2 = 0;
        for (int i = 0; i < 9; i++) begin
            get(l, t);
            chk(l, i[0] ? 4'h2 : 4'h1);
            if (i > 0) begin
                chk((t - t0 == 16'h0001) || (t - t0 == 16'h0002), 1);
                n2 += int'(t - t0 == 16'h0002);
            end
            t0 = t;
        end
        // 72 cycles span exactly nine timer steps over eight intervals
        chk(n2, 1);
        chk({queue_empty, hold_valid}, 2'h2);
        $display("test burst done");
        u_lines.toggle(4'h1);
        repeat (30) @(negedge clk);
        u_lines.toggle(4'h1);
        get(l, t0);
        get(l, t);
        chk(t - t0 > 16'h0002, 1);
        $display("test fresh done");
        u_lines.toggle(4'h4);
        repeat (12) @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        chk({hold_valid, queue_empty, overflow}, 3'h2);
        rst = 1'b0;
        // Counters restart: same timing as the first event after power-up
        repeat (12) @(negedge clk);
        u_lines.toggle(4'h8);
        get(l, t);
        chk(l, 4'h8);
        chk(t, 16'h0002);
        $display("test second reset done");
        stop_test();
    end
endmodule : iett_top_tb
bind iett_top iett_top_asserts #(.NLINES(NLINES), .QDEPTH(QDEPTH)) u_asserts (.clk(clk),
    .rst(rst), .event_lines(event_lines), .hold_read(hold_read), .hold_valid(hold_valid),
    .hold_lines(hold_lines), .hold_tag(hold_tag), .queue_empty(queue_empty),
    .queue_full(queue_full), .overflow(overflow));
